/* rtl/sbgtl_core.sv */
// What this block does
// (R1) Stopped servo off: brake first, then delayed de-energize
// (R2) Running wait bounds servo off to brake
// (R3) Running stop: brake at 30 r/min or wait
// (R4) Servo on only at or below 30 r/min
// (R5) Host waits brake release before commanding motion
// (R6) User sets stopped delay past brake engagement
// (R7) Dynamic brake 10 ms after de-energize
// (R8) Gain switching enable conditions per mode
// (R9) Select input picks gain set one or two
// (R10) User disables autotuning when switching gains
// (R11) Switching mode writable only for method 0-2
// (R12) First condition applies in first mode only
// (R13) Second condition needs second mode and enable
// (R14) Rigidity setting never applies to set two
// (R15) Method 0: min of analog and forward value
// (R16) Forward input 3 V per 100 percent
// (R17) Reverse input -3 V per 100 percent
// (R18) Method 1: forward value both directions
// (R19) Method 2: forward and reverse values separately
// (R20) Method 3: switch input picks forward or reverse
// (R21) Limit values 0 to 300, default 300
`timescale 1ns/1ps
`default_nettype none
module sbgtl_core
    import sbgtl_pkg::*;
#(
    parameter int MS_DIV = MS_CYCLES,
    parameter logic [8:0] LIMIT_MAX = LIMIT_MAX_DEF
)
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Host pins
    input wire logic run_cmd_i,
    input wire logic fault_i,
    input wire logic power_loss_i,
    input wire logic gain_set_select_i,
    input wire logic limit_switch_i,
    input wire logic second_mode_active_i,
    // Internal measurements, same clock
    input wire logic [15:0] motor_speed_i,
    input wire logic signed [15:0] forward_limit_input_i,
    input wire logic signed [15:0] reverse_limit_input_i,
    // Motor and brake control
    output logic brake_interlock_out_o,
    output logic motor_energize_o,
    output logic dynamic_brake_o,
    output logic servo_on_o,
    // Loop gains and limits
    output logic [15:0] position_gain_o,
    output logic [15:0] speed_gain_o,
    output logic [15:0] integration_time_o,
    output logic gain_set_two_o,
    output logic rigidity_apply_o,
    output logic [3:0] rigidity_o,
    output logic [8:0] forward_torque_limit_o,
    output logic [8:0] reverse_torque_limit_o
);

    // Refuse settings the logic cannot serve
    initial
    begin
        if (MS_DIV < 1 || MS_DIV > 1_000_000 || LIMIT_MAX > LIMIT_MAX_DEF)
        begin
            $error("sbgtl_core: MS_DIV or LIMIT_MAX out of range");
        end
    end

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // Clamp a torque limit to the drive maximum
    function automatic logic [8:0] lim_clamp(input logic [8:0] v);
        return (v > LIMIT_MAX) ? LIMIT_MAX : v;
    endfunction

    // Analog millivolts to percent; wrong polarity gives zero
    function automatic logic [8:0] mv_to_pct(input logic signed [15:0] mv, input logic neg);
        logic [15:0] mag;
        logic [15:0] pct;
        mag = 16'h0000;
        if (!neg && mv > 0)
        begin
            mag = mv;
        end
        else if (neg && mv < 0)
        begin
            mag = 16'(-mv);
        end
        pct = mag / MV_PER_PCT_X100;
        return (pct > 16'(LIMIT_MAX)) ? LIMIT_MAX : pct[8:0];
    endfunction

    // Pin synchronisers: first stage read by second stage only
    logic [5:0] pin_meta_q;
    logic [5:0] pin_sync_q;
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_meta_q <= 6'h00;
            pin_sync_q <= 6'h00;
        end
        else
        begin
            pin_meta_q <= {second_mode_active_i, limit_switch_i, gain_set_select_i,
                power_loss_i, fault_i, run_cmd_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    logic run_s;
    logic fault_s;
    logic pwr_loss_s;
    logic gain_set_select_s;
    logic lsw_s;
    logic second_s;
    assign run_s = pin_sync_q[0];
    assign fault_s = pin_sync_q[1];
    assign pwr_loss_s = pin_sync_q[2];
    assign gain_set_select_s = pin_sync_q[3];
    assign lsw_s = pin_sync_q[4];
    assign second_s = pin_sync_q[5];

    // Register words
    logic [31:0] ctrl_q;
    logic [31:0] brake_q;
    logic [31:0] gain1a_q;
    logic [31:0] gain1b_q;
    logic [31:0] gain2a_q;
    logic [31:0] gain2b_q;
    logic [31:0] tune_q;
    logic [31:0] limit_q;

    // Decoded fields
    logic [1:0] method;
    logic sw_mode;
    logic [15:0] stop_delay_ms;
    logic [15:0] run_wait_ms;
    logic [3:0] cond1;
    logic [3:0] cond2;
    logic [8:0] fwd_value;
    logic [8:0] rev_value;
    assign method = ctrl_q[CTRL_METHOD_LSB +: 2];
    assign sw_mode = ctrl_q[CTRL_SWMODE_BIT];
    assign stop_delay_ms = brake_q[BRAKE_STOP_LSB +: 16];
    assign run_wait_ms = brake_q[BRAKE_RUN_LSB +: 16];
    assign cond1 = tune_q[TUNE_COND1_LSB +: 4];
    assign cond2 = tune_q[TUNE_COND2_LSB +: 4];
    assign fwd_value = limit_q[LIMIT_FWD_LSB +: 9];
    assign rev_value = limit_q[LIMIT_REV_LSB +: 9];

    // Bus handshake: one wait cycle, then completion
    logic ack_q;
    logic bus_req;
    logic bus_done;
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_done = bus_req & ack_q;
    assign avs_waitrequest_o = bus_req & ~ack_q;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // Register writes take effect at the completing edge
    logic [31:0] ctrl_w;
    logic [31:0] limit_w;
    always_comb
    begin
        ctrl_w = be_merge(ctrl_q, avs_writedata_i, avs_byteenable_i, MASK_CTRL);
        // Mode bit keeps its value unless the method allows it
        if (method > 2'd2)
        begin
            ctrl_w[CTRL_SWMODE_BIT] = sw_mode; // R11
        end
        limit_w = be_merge(limit_q, avs_writedata_i, avs_byteenable_i, MASK_LIMIT);
        limit_w[LIMIT_FWD_LSB +: 9] = lim_clamp(limit_w[LIMIT_FWD_LSB +: 9]); // R21
        limit_w[LIMIT_REV_LSB +: 9] = lim_clamp(limit_w[LIMIT_REV_LSB +: 9]); // R21
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_q <= RST_CTRL;
            brake_q <= RST_BRAKE;
            gain1a_q <= RST_GAINA;
            gain1b_q <= RST_GAINB;
            gain2a_q <= RST_GAINA;
            gain2b_q <= RST_GAINB;
            tune_q <= RST_TUNE;
            limit_q <= RST_LIMIT; // R21
        end
        else if (bus_done && avs_write_i)
        begin
            // Unmapped offsets and the status word ignore writes
            case (avs_address_i)
                OFS_CTRL: ctrl_q <= ctrl_w;
                OFS_BRAKE: brake_q <= be_merge(brake_q, avs_writedata_i, avs_byteenable_i, MASK_BRAKE);
                OFS_GAIN1A: gain1a_q <= be_merge(gain1a_q, avs_writedata_i, avs_byteenable_i, MASK_GAINA);
                OFS_GAIN1B: gain1b_q <= be_merge(gain1b_q, avs_writedata_i, avs_byteenable_i, MASK_GAINB);
                OFS_GAIN2A: gain2a_q <= be_merge(gain2a_q, avs_writedata_i, avs_byteenable_i, MASK_GAINA);
                OFS_GAIN2B: gain2b_q <= be_merge(gain2b_q, avs_writedata_i, avs_byteenable_i, MASK_GAINB);
                OFS_TUNE: tune_q <= be_merge(tune_q, avs_writedata_i, avs_byteenable_i, MASK_TUNE);
                OFS_LIMIT: limit_q <= limit_w;
                default: ;
            endcase
        end
    end

    // Millisecond tick from the main clock
    logic [19:0] div_q;
    logic ms_tick;
    assign ms_tick = (div_q == 20'(MS_DIV - 1));
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            div_q <= 20'h00000;
        end
        else
        begin
            div_q <= ms_tick ? 20'h00000 : div_q + 20'h00001;
        end
    end

    // Servo sequencing
    sbgtl_state_t state_q;
    logic [15:0] seq_ms_q;
    logic speed_low;
    logic stop_req;
    assign speed_low = (motor_speed_i <= STOP_SPEED_RPM);
    assign stop_req = ~run_s | fault_s | pwr_loss_s;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= S_IDLE;
            seq_ms_q <= 16'h0000;
        end
        else
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    seq_ms_q <= 16'h0000;
                    // A coasting motor must slow down before servo on
                    if (!stop_req && speed_low) // R4
                    begin
                        state_q <= S_ON;
                    end
                end
                S_ON:
                begin
                    seq_ms_q <= 16'h0000;
                    if (stop_req)
                    begin
                        // Stopped motor holds torque while brake engages
                        state_q <= speed_low ? S_STOP_DELAY : S_RUN_WAIT; // R1
                    end
                end
                S_STOP_DELAY:
                begin
                    if (ms_tick)
                    begin
                        seq_ms_q <= seq_ms_q + 16'h0001;
                    end
                    if (seq_ms_q >= stop_delay_ms) // R1
                    begin
                        state_q <= S_IDLE;
                    end
                end
                S_RUN_WAIT:
                begin
                    if (ms_tick)
                    begin
                        seq_ms_q <= seq_ms_q + 16'h0001;
                    end
                    // Braking a fast disk wears it, so wait for low speed
                    if (speed_low || seq_ms_q >= run_wait_ms) // R2 R3
                    begin
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Brake released only while on, or while a running motor coasts down
    assign brake_interlock_out_o = (state_q == S_ON) || (state_q == S_RUN_WAIT); // R1 R3
    assign motor_energize_o = (state_q == S_ON) || (state_q == S_STOP_DELAY); // R1
    assign servo_on_o = (state_q == S_ON);

    // Dynamic brake follows de-energize after a coast interval
    logic [15:0] coast_ms_q;
    logic dyn_q;
    assign dynamic_brake_o = dyn_q;
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            coast_ms_q <= 16'h0000;
            dyn_q <= 1'b0;
        end
        else if (motor_energize_o)
        begin
            coast_ms_q <= 16'h0000;
            dyn_q <= 1'b0;
        end
        else if (coast_ms_q >= DYN_BRAKE_MS)
        begin
            dyn_q <= 1'b1; // R7
        end
        else if (ms_tick)
        begin
            coast_ms_q <= coast_ms_q + 16'h0001;
        end
    end

    // Gain switching enable
    logic composite;
    logic second_active;
    logic first_ok;
    logic second_ok;
    logic switch_en;
    assign composite = ctrl_q[CTRL_COMPOSITE_BIT];
    assign second_active = composite & second_s;
    // First condition counts only in the first mode
    assign first_ok = ~second_active && !(cond1 == 4'h1 || cond1 == 4'h2 || cond1 == 4'h4); // R12
    // Second condition only in speed-controlled second mode
    assign second_ok = second_active && ctrl_q[CTRL_SECOND_SPEED_BIT]
        && !(cond2 == 4'h0 || cond2 == 4'h1); // R13
    assign switch_en = sw_mode && (first_ok || second_ok); // R8

    // Gains and rigidity are registered so they change together
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            gain_set_two_o <= 1'b0;
            position_gain_o <= 16'h0000;
            speed_gain_o <= 16'h0000;
            integration_time_o <= 16'h0000;
            rigidity_apply_o <= 1'b0;
            rigidity_o <= 4'h0;
        end
        else
        begin
            gain_set_two_o <= switch_en & gain_set_select_s; // R8 R9
            if (switch_en && gain_set_select_s)
            begin
                position_gain_o <= gain2a_q[GAIN_POS_LSB +: 16]; // R9
                speed_gain_o <= gain2a_q[GAIN_SPEED_LSB +: 16];
                integration_time_o <= gain2b_q[GAIN_INTEG_LSB +: 16];
                rigidity_apply_o <= 1'b0; // R14
            end
            else
            begin
                position_gain_o <= gain1a_q[GAIN_POS_LSB +: 16]; // R9
                speed_gain_o <= gain1a_q[GAIN_SPEED_LSB +: 16];
                integration_time_o <= gain1b_q[GAIN_INTEG_LSB +: 16];
                rigidity_apply_o <= (tune_q[TUNE_AUTO_LSB +: 4] != 4'h0);
            end
            rigidity_o <= tune_q[TUNE_RIGID_LSB +: 4];
        end
    end

    // Torque limit selection
    logic [8:0] fwd_analog;
    logic [8:0] rev_analog;
    assign fwd_analog = mv_to_pct(forward_limit_input_i, 1'b0); // R16
    assign rev_analog = mv_to_pct(reverse_limit_input_i, 1'b1); // R17

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            forward_torque_limit_o <= 9'h000;
            reverse_torque_limit_o <= 9'h000;
        end
        else
        begin
            unique case (method)
                2'd0:
                begin
                    // Smaller of analog and stored forward value
                    forward_torque_limit_o <= (fwd_analog < fwd_value) ? fwd_analog : fwd_value; // R15
                    reverse_torque_limit_o <= (rev_analog < fwd_value) ? rev_analog : fwd_value; // R15
                end
                2'd1:
                begin
                    forward_torque_limit_o <= fwd_value; // R18
                    reverse_torque_limit_o <= fwd_value;
                end
                2'd2:
                begin
                    forward_torque_limit_o <= fwd_value; // R19
                    reverse_torque_limit_o <= rev_value;
                end
                2'd3:
                begin
                    forward_torque_limit_o <= lsw_s ? rev_value : fwd_value; // R20
                    reverse_torque_limit_o <= lsw_s ? rev_value : fwd_value;
                end
            endcase
        end
    end

    // Read data captured in the wait cycle, stands at completion
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            avs_readdata_o <= 32'h0000_0000;
        end
        else if (avs_read_i && !ack_q)
        begin
            case (avs_address_i)
                OFS_CTRL: avs_readdata_o <= ctrl_q;
                OFS_BRAKE: avs_readdata_o <= brake_q;
                OFS_GAIN1A: avs_readdata_o <= gain1a_q;
                OFS_GAIN1B: avs_readdata_o <= gain1b_q;
                OFS_GAIN2A: avs_readdata_o <= gain2a_q;
                OFS_GAIN2B: avs_readdata_o <= gain2b_q;
                OFS_TUNE: avs_readdata_o <= tune_q;
                OFS_LIMIT: avs_readdata_o <= limit_q;
                OFS_STATUS: avs_readdata_o <= {reverse_torque_limit_o, 8'h00,
                    forward_torque_limit_o, gain_set_two_o, dynamic_brake_o,
                    motor_energize_o, brake_interlock_out_o, 2'(state_q)};
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    property p_r4_idle_slow;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state_q == S_IDLE && !speed_low) |=> (state_q != S_ON);
    endproperty
    a_r4_idle_slow: assert property (p_r4_idle_slow) else $error("servo on while fast"); // R4

    property p_r1_brake_first;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state_q == S_ON && stop_req && speed_low)
        |=> (!brake_interlock_out_o && motor_energize_o);
    endproperty
    a_r1_brake_first: assert property (p_r1_brake_first) else $error("stopped off order"); // R1

    property p_r3_low_speed;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state_q == S_RUN_WAIT && speed_low) |=> !brake_interlock_out_o;
    endproperty
    a_r3_low_speed: assert property (p_r3_low_speed) else $error("brake not output at low speed"); // R3

    property p_r2_wait_bound;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state_q == S_RUN_WAIT) |-> (seq_ms_q <= run_wait_ms);
    endproperty
    a_r2_wait_bound: assert property (p_r2_wait_bound) else $error("running wait overrun"); // R2

    property p_r7_coast;
        @(posedge mclk_i) disable iff (!nrst_i)
        $rose(dynamic_brake_o) |-> (!motor_energize_o && coast_ms_q == DYN_BRAKE_MS);
    endproperty
    a_r7_coast: assert property (p_r7_coast) else $error("dynamic brake timing"); // R7

    property p_r8_disabled;
        @(posedge mclk_i) disable iff (!nrst_i)
        !switch_en |=> !gain_set_two_o;
    endproperty
    a_r8_disabled: assert property (p_r8_disabled) else $error("set two while disabled"); // R8

    property p_r9_set_two;
        @(posedge mclk_i) disable iff (!nrst_i)
        (switch_en && gain_set_select_s) |=> (speed_gain_o == $past(gain2a_q[31:16]) && !rigidity_apply_o);
    endproperty
    a_r9_set_two: assert property (p_r9_set_two) else $error("set two gains wrong"); // R9

    property p_r11_locked;
        @(posedge mclk_i) disable iff (!nrst_i)
        (method == 2'd3 && bus_done && avs_write_i && avs_address_i == OFS_CTRL)
        |=> (sw_mode == $past(sw_mode));
    endproperty
    a_r11_locked: assert property (p_r11_locked) else $error("mode written under method 3"); // R11

    property p_r15_min;
        @(posedge mclk_i) disable iff (!nrst_i)
        (method == 2'd0) |=> (forward_torque_limit_o <= $past(fwd_value));
    endproperty
    a_r15_min: assert property (p_r15_min) else $error("method 0 limit too high"); // R15

    property p_r20_switch;
        @(posedge mclk_i) disable iff (!nrst_i)
        (method == 2'd3 && lsw_s) |=> (reverse_torque_limit_o == $past(rev_value));
    endproperty
    a_r20_switch: assert property (p_r20_switch) else $error("method 3 limit wrong"); // R20

    property p_r21_range;
        @(posedge mclk_i) disable iff (!nrst_i)
        (fwd_value <= LIMIT_MAX) && (rev_value <= LIMIT_MAX);
    endproperty
    a_r21_range: assert property (p_r21_range) else $error("limit value over maximum"); // R21

endmodule
`default_nettype wire

/* rtl/sbgtl_pkg.sv */
package sbgtl_pkg;

    // Register byte offsets (one aligned 32-bit word each)
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_BRAKE = 6'h04;
    localparam logic [5:0] OFS_GAIN1A = 6'h08;
    localparam logic [5:0] OFS_GAIN1B = 6'h0C;
    localparam logic [5:0] OFS_GAIN2A = 6'h10;
    localparam logic [5:0] OFS_GAIN2B = 6'h14;
    localparam logic [5:0] OFS_TUNE = 6'h18;
    localparam logic [5:0] OFS_LIMIT = 6'h1C;
    localparam logic [5:0] OFS_STATUS = 6'h20;

    // Writable bits of each register; reserved bits read as zero
    localparam logic [31:0] MASK_CTRL = 32'h0003_0103;
    localparam logic [31:0] MASK_BRAKE = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_GAINA = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_GAINB = 32'h0000_FFFF;
    localparam logic [31:0] MASK_TUNE = 32'h0000_FFFF;
    localparam logic [31:0] MASK_LIMIT = 32'h01FF_01FF;

    // Field positions
    localparam int CTRL_METHOD_LSB = 0;
    localparam int CTRL_SWMODE_BIT = 8;
    localparam int CTRL_COMPOSITE_BIT = 16;
    localparam int CTRL_SECOND_SPEED_BIT = 17;
    localparam int BRAKE_STOP_LSB = 0;
    localparam int BRAKE_RUN_LSB = 16;
    localparam int GAIN_POS_LSB = 0;
    localparam int GAIN_SPEED_LSB = 16;
    localparam int GAIN_INTEG_LSB = 0;
    localparam int TUNE_AUTO_LSB = 0;
    localparam int TUNE_RIGID_LSB = 4;
    localparam int TUNE_COND1_LSB = 8;
    localparam int TUNE_COND2_LSB = 12;
    localparam int LIMIT_FWD_LSB = 0;
    localparam int LIMIT_REV_LSB = 16;

    // Reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_BRAKE = 32'h0000_0000;
    localparam logic [31:0] RST_GAINA = 32'h0000_0000;
    localparam logic [31:0] RST_GAINB = 32'h0000_0000;
    localparam logic [31:0] RST_TUNE = 32'h0000_0000;
    localparam logic [31:0] RST_LIMIT = 32'h012C_012C;

    // Timing and scaling
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_TIME = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
    localparam logic [15:0] DYN_BRAKE_MS = 16'h000A;
    localparam logic [15:0] STOP_SPEED_RPM = 16'h001E;
    localparam logic [15:0] MV_PER_PCT_X100 = 16'h001E;
    localparam logic [8:0] LIMIT_MAX_DEF = 9'h12C;

    // Servo sequence states
    typedef enum logic [1:0] {S_IDLE, S_ON, S_STOP_DELAY, S_RUN_WAIT} sbgtl_state_t;

endpackage

/* testbench/sbgtl_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Motor with inertia: follows the bench while loaded, coasts once de-energized
module sbgtl_motor_model
(
    input wire logic mclk_i,
    input wire logic load_i,
    input wire logic [15:0] spin_i,
    input wire logic energize_i,
    output logic [15:0] speed_o
);
    // Coasting sheds one r/min a cycle, so a stop never looks instant
    always_ff @(posedge mclk_i)
    begin
        if (load_i)
            speed_o <= spin_i;
        else if (!energize_i && speed_o != 16'h0000)
            speed_o <= speed_o - 16'h0001;
    end
endmodule
`default_nettype wire

/* testbench/tb_servo_brake_gain_torque_limit.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_servo_brake_gain_torque_limit;
    import sbgtl_pkg::*;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic rd = 1'b0, wr = 1'b0, run = 1'b0, gain_set_select = 1'b0, lsw = 1'b0, ld = 1'b1;
    logic sec = 1'b0;
    logic [3:0] rg;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0000_0000, q, rdat;
    logic [15:0] spin = 16'h0000, speed, pg, sg, it;
    logic signed [15:0] fmv = 16'sh0000, rmv = 16'sh0000;
    logic wreq, brk, en, dyn, son, two, ra;
    logic [8:0] fl, rl;
    int errors = 0;
    int cmp_count = 0;
    // Free-running 100 MHz clock
    always #5 mclk_i = ~mclk_i;
    sbgtl_core #(.MS_DIV(10)) sbgtl_core_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hF), .avs_readdata_o(q), .avs_waitrequest_o(wreq),
        .run_cmd_i(run), .fault_i(1'b0), .power_loss_i(1'b0), .gain_set_select_i(gain_set_select),
        .limit_switch_i(lsw), .second_mode_active_i(sec), .motor_speed_i(speed),
        .forward_limit_input_i(fmv), .reverse_limit_input_i(rmv),
        .brake_interlock_out_o(brk), .motor_energize_o(en), .dynamic_brake_o(dyn),
        .servo_on_o(son), .position_gain_o(pg), .speed_gain_o(sg), .integration_time_o(it),
        .gain_set_two_o(two), .rigidity_apply_o(ra), .rigidity_o(rg),
        .forward_torque_limit_o(fl), .reverse_torque_limit_o(rl));
    sbgtl_motor_model sbgtl_motor_model_inst (.mclk_i(mclk_i), .load_i(ld), .spin_i(spin),
        .energize_i(en), .speed_o(speed));
    task automatic results;
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic st(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // One Avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        logic ok;
        n = 0;
        ok = 1'b0;
        adr <= a;
        wd <= d;
        rd <= ~w;
        wr <= w;
        // Completion is the edge at which waitrequest is sampled low
        while (n < 50 && !ok)
        begin
            @(posedge mclk_i);
            n++;
            ok = (wreq === 1'b0);
        end
        rdat = q;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk_i);
        if (!ok)
        begin
            errors++;
            results();
        end
    endtask
    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(rdat, e)
    endtask
    task automatic t_torque;
        rc(OFS_LIMIT, 32'h012C_012C);
        bus(1'b1, OFS_LIMIT, 32'h0FFF_0032);
        rc(OFS_LIMIT, 32'h012C_0032);
        bus(1'b1, OFS_LIMIT, 32'h0032_0064);
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        st(3);
        `CHK({fl, rl}, 18'h0C864)
        bus(1'b1, OFS_CTRL, 32'h0000_0002);
        st(3);
        `CHK({fl, rl}, 18'h0C832)
        // Mode bit is locked only once method 3 already stands
        bus(1'b1, OFS_CTRL, 32'h0000_0003);
        bus(1'b1, OFS_CTRL, 32'h0000_0103);
        rc(OFS_CTRL, 32'h0000_0003);
        `CHK({fl, rl}, 18'h0C864)
        lsw <= 1'b1;
        st(6);
        `CHK({fl, rl}, 18'h06432)
        fmv <= 16'sh05DC;
        rmv <= 16'shE890;
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        st(3);
        `CHK({fl, rl}, 18'h06464)
        // Coast timer runs from reset, so the dynamic brake is on by now
        st(80);
        rc(OFS_STATUS, 32'h3200_0C90);
        $display("torque done");
    endtask
    task automatic t_gain;
        bus(1'b1, OFS_GAIN1A, 32'h0011_0022);
        bus(1'b1, OFS_GAIN1B, 32'h0000_0033);
        bus(1'b1, OFS_GAIN2A, 32'h0044_0055);
        bus(1'b1, OFS_GAIN2B, 32'h0000_0066);
        bus(1'b1, OFS_TUNE, 32'h0000_0051);
        bus(1'b1, OFS_CTRL, 32'h0000_0100);
        gain_set_select <= 1'b1;
        st(6);
        `CHK({two, ra, pg, sg, it}, 50'h2_0055_0044_0066)
        `CHK(rg, 4'h5)
        gain_set_select <= 1'b0;
        st(6);
        `CHK({two, ra, pg, sg, it}, 50'h1_0022_0011_0033)
        bus(1'b1, OFS_TUNE, 32'h0000_0151);
        gain_set_select <= 1'b1;
        st(6);
        `CHK(two, 1'b0)
        // Autotuning off from here; second mode switches on its own condition
        bus(1'b1, OFS_TUNE, 32'h0000_2150);
        bus(1'b1, OFS_CTRL, 32'h0003_0100);
        sec <= 1'b1;
        st(6);
        `CHK(two, 1'b1)
        sec <= 1'b0;
        st(6);
        `CHK(two, 1'b0)
        $display("gain done");
    endtask
    task automatic t_brake;
        // Stopped delay of 100 ms covers the brake engaging time
        bus(1'b1, OFS_BRAKE, 32'h0005_0064);
        spin <= 16'h0064;
        run <= 1'b1;
        st(8);
        `CHK(son, 1'b0)
        spin <= 16'h0000;
        st(8);
        `CHK({son, brk, en}, 3'h7)
        run <= 1'b0;
        st(6);
        `CHK({brk, en}, 2'h1)
        st(900);
        `CHK({brk, en}, 2'h1)
        st(130);
        `CHK({brk, en, dyn}, 3'h0)
        st(40);
        `CHK(dyn, 1'b0)
        st(60);
        `CHK(dyn, 1'b1)
        run <= 1'b1;
        st(2000);
        spin <= 16'h00C8;
        st(2);
        ld <= 1'b0;
        run <= 1'b0;
        st(20);
        `CHK({brk, en}, 2'h2)
        st(50);
        `CHK(brk, 1'b0)
        // Long running wait, so the low-speed event ends it
        bus(1'b1, OFS_BRAKE, 32'h0064_0064);
        spin <= 16'h0000;
        ld <= 1'b1;
        run <= 1'b1;
        st(2000);
        spin <= 16'h00C8;
        st(2);
        ld <= 1'b0;
        run <= 1'b0;
        st(150);
        `CHK(brk, 1'b1)
        st(40);
        `CHK(brk, 1'b0)
        $display("brake done");
    endtask
    // Reset for 12 cycles, then the scenarios in turn
    initial
    begin
        st(12);
        nrst_i <= 1'b1;
        st(2);
        t_torque();
        t_gain();
        t_brake();
        results();
    end
endmodule
`default_nettype wire
